// File: rtl/timer_array.sv
/*
 * Timer array top: AHB-Lite register slave, channels and output logic.
 * Assumes single word transfers and a synchronous input pin per channel.
 */
`timescale 1ns/1ns
`default_nettype none
module timer_array
	import timer_pkg::*;
#(
	parameter int NUM_CH = 4,  // 4 on the large variant, 2 otherwise
	parameter int CNT_W  = 16
) (
	input  wire logic              hclk,            // clock
	input  wire logic              hresetn,         // async reset, low
	input  wire logic              ce,              // clock enable
	input  wire logic              hsel,            // slave select
	input  wire logic [31:0]       haddr,           // address
	input  wire logic [1:0]        htrans,          // transfer type
	input  wire logic              hwrite,          // write
	input  wire logic [2:0]        hsize,           // size
	input  wire logic [31:0]       hwdata,          // write data
	input  wire logic              hready,          // bus ready
	output logic [31:0]            hrdata,          // read data
	output logic                   hreadyout,       // slave ready
	output logic                   hresp,           // response
	input  wire logic [NUM_CH-1:0] timer_input_pin, // input pins
	output logic [NUM_CH-1:0]      timer_output,    // output pins
	output logic [NUM_CH-1:0]      irq_req          // irq request pulses
);

	// ****************************************************************
	// bus slave
	// ****************************************************************
	logic [ADDR_W-1:0] addr_reg;
	logic              wr_pend_reg;
	logic              rd_pend_reg;
	logic [31:0]       hrdata_reg;
	logic [31:0]       rd_mux;

	// reads take one wait state so a read just after a write sees it
	wire logic accept = hsel & htrans[1] & hready & (hsize == HSIZE_WORD);
	wire logic wr_go  = wr_pend_reg & ce;

	assign hreadyout = ce & ~rd_pend_reg;
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_reg;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			addr_reg    <= '0;
			wr_pend_reg <= 1'b0;
			rd_pend_reg <= 1'b0;
			hrdata_reg  <= '0;
		end else if (ce) begin
			wr_pend_reg <= accept & hwrite;
			rd_pend_reg <= accept & ~hwrite;
			if (accept) begin
				addr_reg <= haddr[ADDR_W-1:0];
			end
			if (rd_pend_reg) begin
				hrdata_reg <= rd_mux;
			end
		end
	end

	// ****************************************************************
	// shared output registers
	// ****************************************************************
	logic [NUM_CH-1:0] out_mode_reg;
	logic [NUM_CH-1:0] polarity_reg;
	logic [NUM_CH-1:0] level_reg;
	logic [NUM_CH-1:0] level_next;
	logic [NUM_CH-1:0] out_en_reg;
	logic [NUM_CH-1:0] pin_reg;
	logic [NUM_CH-1:0] running;

	wire logic wr_out_mode = wr_go & (addr_reg == OFS_OUT_MODE);
	wire logic wr_polarity = wr_go & (addr_reg == OFS_POLARITY);
	wire logic wr_level    = wr_go & (addr_reg == OFS_LEVEL);
	wire logic wr_out_en   = wr_go & (addr_reg == OFS_OUT_EN);
	wire logic wr_start    = wr_go & (addr_reg == OFS_START);
	wire logic wr_stop     = wr_go & (addr_reg == OFS_STOP);

	// channel 0 is always the master; its mode bit is hardwired low
	wire logic [NUM_CH-1:0] out_mode_wdata = hwdata[NUM_CH-1:0] & ~NUM_CH'(1);
	wire logic [NUM_CH-1:0] start_vec      = wr_start ? hwdata[NUM_CH-1:0] : '0;
	wire logic [NUM_CH-1:0] stop_vec       = wr_stop ? hwdata[NUM_CH-1:0] : '0;
	wire logic              master_irq     = irq_req[0];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			out_mode_reg <= '0;
			polarity_reg <= '0;
			out_en_reg   <= '0;
		end else if (ce) begin
			if (wr_out_mode) begin
				out_mode_reg <= out_mode_wdata;
			end
			if (wr_polarity) begin
				polarity_reg <= hwdata[NUM_CH-1:0];
			end
			if (wr_out_en) begin
				out_en_reg <= hwdata[NUM_CH-1:0];
			end
		end
	end

	// ****************************************************************
	// channels
	// ****************************************************************
	logic [15:0]      mode_cfg_reg [NUM_CH];
	logic [CNT_W-1:0] data_reg     [NUM_CH];
	logic [CNT_W-1:0] count        [NUM_CH];
	logic [CNT_W-1:0] capture      [NUM_CH];

	for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
		wire logic wr_mode = wr_go & (addr_reg == chan_ofs(OFS_MODE_BASE, CH_STRIDE, ch));
		wire logic wr_data = wr_go & (addr_reg == chan_ofs(OFS_DATA_BASE, CH_STRIDE, ch));
		wire logic own_irq = irq_req[ch];
		wire logic slave   = out_mode_reg[ch];

		// slave: set wins when both irqs coincide, so 100 % duty holds high
		wire logic timer_level = slave ?
		                         (master_irq ? 1'b1 : (own_irq ? 1'b0 : level_reg[ch])) :
		                         (own_irq ? ~level_reg[ch] : level_reg[ch]);

		assign level_next[ch] = out_en_reg[ch] ? timer_level :
		                        (wr_level ? hwdata[ch] : level_reg[ch]);

		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn) begin
				mode_cfg_reg[ch] <= MODE_CFG_RST;
				data_reg[ch]     <= CNT_W'(DATA_RST);
				level_reg[ch]    <= 1'b0;
				pin_reg[ch]      <= 1'b0;
			end else if (ce) begin
				if (wr_mode) begin
					mode_cfg_reg[ch] <= hwdata[15:0];
				end
				if (wr_data) begin
					data_reg[ch] <= hwdata[CNT_W-1:0];
				end
				level_reg[ch] <= level_next[ch];
				// pin follows the next level with the next polarity applied, so it matches both flops
				pin_reg[ch]   <= level_next[ch] ^ (wr_polarity ? hwdata[ch] : polarity_reg[ch]);
			end
		end

		timer_channel #(
			.CNT_W (CNT_W)
		) u_chan (
			.hclk       (hclk),
			.hresetn    (hresetn),
			.ce         (ce),
			.mode_cfg   (mode_cfg_reg[ch]),
			.cmp_value  (data_reg[ch]),
			.sw_start   (start_vec[ch]),
			.sw_stop    (stop_vec[ch]),
			.pin_in     (timer_input_pin[ch]),
			.master_irq (master_irq),
			.irq        (irq_req[ch]),
			.count      (count[ch]),
			.capture    (capture[ch]),
			.running    (running[ch])
		);
	end

	assign timer_output = pin_reg;

	// ****************************************************************
	// read mux
	// ****************************************************************
	// unmapped offsets and bits above the channel count read as zero
	always_comb begin
		rd_mux = '0;
		for (int ch = 0; ch < NUM_CH; ch++) begin
			if (addr_reg == chan_ofs(OFS_MODE_BASE, CH_STRIDE, ch)) begin
				rd_mux = {16'h0000, mode_cfg_reg[ch]};
			end
			if (addr_reg == chan_ofs(OFS_DATA_BASE, CH_STRIDE, ch)) begin
				rd_mux = 32'(data_reg[ch]);
			end
			if (addr_reg == chan_ofs(OFS_CNT_BASE, CNT_STRIDE, ch)) begin
				rd_mux = {16'(capture[ch]), 16'(count[ch])};
			end
		end
		case (addr_reg)
			OFS_OUT_MODE: rd_mux = 32'(out_mode_reg);
			OFS_POLARITY: rd_mux = 32'(polarity_reg);
			OFS_LEVEL:    rd_mux = 32'(level_reg);
			OFS_OUT_EN:   rd_mux = 32'(out_en_reg);
			OFS_RUNNING:  rd_mux = 32'(running);
			default:      rd_mux = rd_mux;
		endcase
	end

endmodule : timer_array
`default_nettype wire

// File: include/timer_pkg.sv
/*
 * Constants, register map, field layout and mode decoding for the timer array.
 * Assumes one timer operation clock (hclk) and an AHB-Lite slave port.
 */
// Notes on behaviour
// - two edge bits pick the input valid edge
// - mode 000 is interval timer counting down
// - mode 010 is capture counting up
// - mode 0110 counts events down, no start irq
// - mode 100 is one-count counting down
// - one-count option bit enables retrigger with irq
// - mode 1100 measures level width, no retrigger
// - option bit gives start irq in interval/capture
// - each channel holds a 16-bit data value
// - output mode 0 toggles on own irq
// - output mode 1: master sets, own clears
// - polarity bit inverts the output pin
// - output level bits, upper bits read zero
// - one output enable bit per channel
// - channels 2 and 3 only on large variant
// - enabled output follows timer, writes ignored
// - start source 100 uses master irq
package timer_pkg;

	// ****************************************************************
	// register map (byte offsets, low 8 address bits)
	// ****************************************************************
	localparam int         ADDR_W        = 8;
	localparam logic [7:0] OFS_MODE_BASE = 8'h00;
	localparam logic [7:0] OFS_DATA_BASE = 8'h04;
	localparam logic [7:0] CH_STRIDE     = 8'h08;
	localparam logic [7:0] OFS_CNT_BASE  = 8'h20;
	localparam logic [7:0] CNT_STRIDE    = 8'h04;
	localparam logic [7:0] OFS_OUT_MODE  = 8'h30;
	localparam logic [7:0] OFS_POLARITY  = 8'h34;
	localparam logic [7:0] OFS_LEVEL     = 8'h38;
	localparam logic [7:0] OFS_OUT_EN    = 8'h3c;
	localparam logic [7:0] OFS_START     = 8'h40;
	localparam logic [7:0] OFS_STOP      = 8'h44;
	localparam logic [7:0] OFS_RUNNING   = 8'h48;

	// ****************************************************************
	// mode register fields and reset values
	// ****************************************************************
	localparam int         EDGE_HI_BIT   = 7;
	localparam int         EDGE_LO_BIT   = 6;
	localparam int         SRC_LSB       = 8;
	localparam int         OPT_BIT       = 0;
	localparam logic [2:0] SRC_SW        = 3'h0;
	localparam logic [2:0] SRC_EDGE      = 3'h1;
	localparam logic [2:0] SRC_BOTH      = 3'h2;
	localparam logic [2:0] SRC_MASTER    = 3'h4;
	localparam logic [1:0] EDGE_FALL     = 2'h0;
	localparam logic [1:0] EDGE_RISE     = 2'h1;
	localparam logic [15:0] MODE_CFG_RST = 16'h0000;
	localparam logic [15:0] DATA_RST     = 16'h0000;
	localparam logic [2:0] HSIZE_WORD    = 3'h2;

	typedef enum logic [2:0] {
		MODE_INTERVAL,
		MODE_CAPTURE,
		MODE_EVENT,
		MODE_ONECOUNT,
		MODE_CAPONE,
		MODE_BAD
	} op_mode_t;

	function automatic op_mode_t decode_mode(input logic [3:0] md);
		case (md[3:1])
			3'h0: decode_mode = MODE_INTERVAL;
			3'h2: decode_mode = MODE_CAPTURE;
			3'h3: decode_mode = md[0] ? MODE_BAD : MODE_EVENT;
			3'h4: decode_mode = MODE_ONECOUNT;
			3'h6: decode_mode = md[0] ? MODE_BAD : MODE_CAPONE;
			default: decode_mode = MODE_BAD;
		endcase
	endfunction : decode_mode

	function automatic logic [7:0] chan_ofs(input logic [7:0] base, input logic [7:0] stride,
		input int ch);
		chan_ofs = base + 8'(stride * 8'(ch));
	endfunction : chan_ofs

endpackage : timer_pkg

// File: rtl/timer_channel.sv
/*
 * One timer channel: edge detection, trigger selection and the counter.
 * Assumes the pin input is synchronous to hclk and the mode is a legal one.
 */
`timescale 1ns/1ns
`default_nettype none
module timer_channel
	import timer_pkg::*;
#(
	parameter int CNT_W = 16
) (
	input  wire logic             hclk,       // operation clock
	input  wire logic             hresetn,    // async reset, low
	input  wire logic             ce,         // clock enable
	input  wire logic [15:0]      mode_cfg,   // channel mode register
	input  wire logic [CNT_W-1:0] cmp_value,  // data register
	input  wire logic             sw_start,   // software start pulse
	input  wire logic             sw_stop,    // software stop pulse
	input  wire logic             pin_in,     // timer input pin
	input  wire logic             master_irq, // master channel irq
	output logic                  irq,        // interrupt request pulse
	output logic [CNT_W-1:0]      count,      // counter value
	output logic [CNT_W-1:0]      capture,    // captured value
	output logic                  running     // channel counting
);

	// ****************************************************************
	// triggers
	// ****************************************************************
	typedef enum logic { ST_IDLE, ST_RUN } chan_state_t;

	chan_state_t      state_reg;
	chan_state_t      state_next;
	logic             pin_prev_reg;
	logic [CNT_W-1:0] count_next;
	logic [CNT_W-1:0] capture_next;
	logic             irq_next;

	wire op_mode_t   mode       = decode_mode(mode_cfg[3:0]);
	wire logic       opt        = mode_cfg[OPT_BIT];
	wire logic [1:0] edge_sel   = mode_cfg[EDGE_HI_BIT:EDGE_LO_BIT];
	wire logic [2:0] src        = mode_cfg[SRC_LSB+2:SRC_LSB];
	wire logic       rise       = pin_in & ~pin_prev_reg;
	wire logic       fall       = ~pin_in & pin_prev_reg;
	wire logic       valid_edge = (edge_sel == EDGE_FALL) ? fall :
	                              (edge_sel == EDGE_RISE) ? rise : (rise | fall);
	// level width: low width opens on fall, high width on rise
	wire logic       begin_edge = edge_sel[0] ? rise : fall;
	wire logic       end_edge   = edge_sel[0] ? fall : rise;
	wire logic       hw_trig    = ((src == SRC_EDGE) & valid_edge) |
	                              ((src == SRC_BOTH) & (rise | fall)) |
	                              ((src == SRC_MASTER) & master_irq);
	wire logic       trig       = sw_start | hw_trig;
	wire logic       count_up   = (mode == MODE_CAPTURE) | (mode == MODE_CAPONE);
	wire logic       tick       = (mode == MODE_EVENT) ? valid_edge : 1'b1;
	wire logic       zero       = (count == '0);
	wire logic       start_now  = (mode == MODE_CAPONE) ? (sw_start | begin_edge) :
	                              (mode != MODE_BAD) & trig;
	wire logic       start_irq  = opt & ((mode == MODE_INTERVAL) | (mode == MODE_CAPTURE));

	// ****************************************************************
	// counter
	// ****************************************************************
	always_comb begin
		state_next   = state_reg;
		count_next   = count;
		capture_next = capture;
		irq_next     = 1'b0;
		case (state_reg)
			ST_IDLE: begin
				if (start_now) begin
					state_next = ST_RUN;
					count_next = count_up ? '0 : cmp_value;
					irq_next   = start_irq;
				end
			end
			ST_RUN: begin
				if (sw_stop) begin
					state_next = ST_IDLE;
				end else begin
					case (mode)
						MODE_INTERVAL, MODE_EVENT: begin
							if (tick && zero) begin
								count_next = cmp_value;
								irq_next   = 1'b1;
							end else if (tick) begin
								count_next = count - 1'b1;
							end
						end
						MODE_CAPTURE: begin
							if (hw_trig) begin
								capture_next = count;
								count_next   = '0;
								irq_next     = 1'b1;
							end else begin
								count_next = count + 1'b1;
							end
						end
						MODE_ONECOUNT: begin
							if (trig && opt) begin
								count_next = cmp_value;
								irq_next   = 1'b1;
							end else if (zero) begin
								irq_next   = 1'b1;
								state_next = ST_IDLE;
							end else begin
								count_next = count - 1'b1;
							end
						end
						MODE_CAPONE: begin
							if (end_edge) begin
								capture_next = count;
								irq_next     = 1'b1;
								state_next   = ST_IDLE;
							end else begin
								count_next = count + 1'b1;
							end
						end
						default: state_next = ST_IDLE;
					endcase
				end
			end
			default: state_next = ST_IDLE;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg    <= ST_IDLE;
			pin_prev_reg <= 1'b0;
			count        <= '0;
			capture      <= '0;
			irq          <= 1'b0;
		end else if (ce) begin
			state_reg    <= state_next;
			pin_prev_reg <= pin_in;
			count        <= count_next;
			capture      <= capture_next;
			irq          <= irq_next;
		end
	end

	assign running = (state_reg == ST_RUN);

endmodule : timer_channel
`default_nettype wire

// File: verification/timer_array_assertions.sv
/*
 * Checker for the timer array top: bus timing and output causes.
 * Assumes it is bound to the top module and sees only its ports.
 */
`timescale 1ns/1ns
`default_nettype none
module timer_array_assertions #(
	parameter int NUM_CH = 4
) (
	input wire logic              hclk,         // clock
	input wire logic              hresetn,      // reset, low
	input wire logic              ce,           // clock enable
	input wire logic              hsel,         // slave select
	input wire logic [1:0]        htrans,       // transfer type
	input wire logic              hwrite,       // write
	input wire logic [2:0]        hsize,        // size
	input wire logic              hready,       // bus ready
	input wire logic [31:0]       hrdata,       // read data
	input wire logic              hreadyout,    // slave ready
	input wire logic              hresp,        // response
	input wire logic [NUM_CH-1:0] irq_req,      // irq pulses
	input wire logic [NUM_CH-1:0] timer_output  // output pins
);
	// ****************************************************************
	// data phase tracking
	// ****************************************************************
	logic taken;
	logic rd_dp;
	logic wr_dp;
	logic seen_wr;
	assign taken = hsel & htrans[1] & hready & (hsize == 3'h2);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_dp <= 1'b0;
			wr_dp <= 1'b0;
			seen_wr <= 1'b0;
		end else begin
			rd_dp <= taken & ~hwrite;
			wr_dp <= taken & hwrite;
			seen_wr <= seen_wr | wr_dp;
		end
	end
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// ****************************************************************
	// properties
	// ****************************************************************
	chk_resp_okay: assert property (hresp == 1'b0)
		else $error("response not okay");
	chk_read_wait: assert property (taken && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");
	chk_write_nowait: assert property (taken && hwrite |=> hreadyout)
		else $error("write stalled");
	chk_ce_stall: assert property (!ce |-> !hreadyout)
		else $error("ready while frozen");
	chk_rdata_hold: assert property ($changed(hrdata) |-> $past(rd_dp))
		else $error("read data moved without read");
	chk_out_cause: assert property ($changed(timer_output) |-> wr_dp || $past(wr_dp)
		|| irq_req != '0 || $past(irq_req) != '0 || $past(irq_req, 2) != '0)
		else $error("output moved without cause");
	chk_irq_needs_cfg: assert property (irq_req != '0 |-> seen_wr)
		else $error("irq before any write");
	chk_out_needs_cfg: assert property (timer_output != '0 |-> seen_wr || wr_dp)
		else $error("output active before any write");
endmodule : timer_array_assertions
bind timer_array timer_array_assertions #(.NUM_CH(NUM_CH)) u_chk (.hclk(hclk),
	.hresetn(hresetn), .ce(ce), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
	.hsize(hsize), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
	.hresp(hresp), .irq_req(irq_req), .timer_output(timer_output));
`default_nettype wire

// File: verification/timer_io_partner.sv
/*
 * Far side of the timer pins: drives the input pins, loads the outputs.
 * Assumes toggle requests arrive just after a rising edge.
 */
`timescale 1ns/1ns
`default_nettype none
module timer_io_partner #(
	parameter int NUM_CH = 4
) (
	input  wire logic              hclk,         // clock
	input  wire logic              hresetn,      // reset, low
	input  wire logic [NUM_CH-1:0] flip,         // toggle request per pin
	input  wire logic [NUM_CH-1:0] timer_output, // load side
	output logic      [NUM_CH-1:0] pin,          // input pins
	output var int                 rises         // pulses seen on channel 1
);
	logic prev;
	// pins change only after an edge, so the sampler never sees a race
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pin <= '0;
			prev <= 1'b0;
			rises <= 0;
		end else begin
			pin <= pin ^ flip;
			prev <= timer_output[1];
			if (timer_output[1] && !prev) begin
				rises <= rises + 1;
			end
		end
	end
endmodule : timer_io_partner
`default_nettype wire

// File: verification/timer_array_tb.sv
/*
 * Self-checking bench for the timer array with a register and output model.
 * Assumes the checker is bound and the pin partner sits on the pins.
 */
`timescale 1ns/1ns
`default_nettype none
module timer_array_tb;
	import timer_pkg::*;
	localparam int NC = 4;
	logic        hclk = 1'b0, hresetn = 1'b0, ce = 1'b1, hsel = 1'b0, hwrite = 1'b0;
	logic [31:0] haddr = '0, hwdata = '0, hrdata, r;
	logic [1:0]  htrans = '0;
	logic [2:0]  hsize = HSIZE_WORD;
	logic        hreadyout, hresp;
	logic [3:0]  pin, tout, irq, irq_q = '0, flip = '0;
	logic [3:0]  lvl_m = '0, pol_m = '0, en_m = '0, om_m = '0;
	logic [15:0] regm [8] = '{default: 16'h0};
	logic [3:0]  mds [8] = '{4'h0, 4'h1, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9, 4'hc};
	logic [2:0]  srcs [4] = '{SRC_SW, SRC_EDGE, SRC_BOTH, SRC_MASTER};
	int          failures = 0, check_count = 0, cyc = 0, quiet = 0, rises, n;
	int          cnt [NC], gap [NC], last [NC];
	timer_array #(.NUM_CH(NC), .CNT_W(16)) u_timer_array (.hclk(hclk), .hresetn(hresetn),
		.ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .timer_input_pin(pin),
		.timer_output(tout), .irq_req(irq));
	timer_io_partner #(.NUM_CH(NC)) u_timer_io_partner (.hclk(hclk), .hresetn(hresetn),
		.flip(flip), .timer_output(tout), .pin(pin), .rises(rises));
	always #5 hclk = ~hclk;
	// ****************************************************************
	// checks, bus tasks and model
	// ****************************************************************
	task automatic close_out;
		if (failures == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : close_out
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		// ready and read data are judged at the rising edge itself
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask : xfer
	function automatic logic [31:0] expv(input logic [7:0] a);
		case (a)
			OFS_OUT_MODE: return {28'h0, om_m};
			OFS_POLARITY: return {28'h0, pol_m};
			OFS_LEVEL: return {28'h0, lvl_m};
			OFS_OUT_EN: return {28'h0, en_m};
			default: return (a < 8'h20) ? {16'h0, regm[a[4:2]]} : 32'h0;
		endcase
	endfunction : expv
	task automatic rd(input logic [7:0] a);
		xfer(1'b0, a, 32'h0);
		chk(r, expv(a));
	endtask : rd
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
		// enabled level bits belong to the timer, not to software
		case (a)
			OFS_OUT_MODE: om_m = d[3:0] & 4'he;
			OFS_POLARITY: pol_m = d[3:0];
			OFS_OUT_EN: en_m = d[3:0];
			OFS_LEVEL: lvl_m = (lvl_m & en_m) | (d[3:0] & ~en_m);
			default: if (a < 8'h20) regm[a[4:2]] = d[15:0] & (a[2] ? 16'hffff : 16'h07cf);
		endcase
		quiet = 4;
	endtask : wr
	task automatic idle(input int k);
		repeat (k) @(posedge hclk);
	endtask : idle
	task automatic pins(input int ch, input int k, input int g);
		repeat (k) begin
			flip[ch] <= 1'b1;
			@(posedge hclk);
			flip[ch] <= 1'b0;
			idle(g);
		end
	endtask : pins
	// output model; compared only away from irq and write edges
	always @(posedge hclk) begin
		cyc++;
		if (cyc > 20000) begin
			failures++;
			close_out();
		end
		if (quiet > 0)
			quiet--;
		else if (irq == '0 && irq_q == '0)
			chk(tout, lvl_m ^ pol_m);
		for (int i = 0; i < NC; i++) begin
			if (irq[i]) begin
				cnt[i]++;
				gap[i] = cyc - last[i];
				last[i] = cyc;
			end
			if (en_m[i] && om_m[i] && irq[0])
				lvl_m[i] = 1'b1;
			else if (en_m[i] && irq[i])
				lvl_m[i] = om_m[i] ? 1'b0 : ~lvl_m[i];
		end
		irq_q <= irq;
	end
	// ****************************************************************
	// scenarios
	// ****************************************************************
	initial begin
		void'($urandom(62));
		idle(16);
		hresetn <= 1'b1;
		idle(1);
		for (int a = 0; a < 'h50; a += 4) if (a != 'h40 && a != 'h44) rd(8'(a));
		repeat (4) begin
			for (int c = 0; c < NC; c++) begin
				wr(8'(8 * c + 4), $urandom & 32'hffff);
				wr(8'(8 * c), {21'h0, srcs[$urandom % 4], 2'($urandom), 2'h0, mds[$urandom % 8]});
			end
			wr(OFS_OUT_MODE, $urandom);
			wr(OFS_POLARITY, $urandom);
			wr(OFS_OUT_EN, $urandom);
			wr(OFS_LEVEL, $urandom);
			for (int a = 0; a < 'h40; a += 4) rd(8'(a));
		end
		wr(8'h80, $urandom);
		rd(8'h80);
		for (int c = 0; c < NC; c++) wr(8'(8 * c), 32'h0);
		wr(OFS_OUT_MODE, 32'h0);
		wr(OFS_OUT_EN, 32'h3);
		for (int o = 0; o < 2; o++) begin
			wr(OFS_DATA_BASE, 32'd6);
			wr(OFS_MODE_BASE, o);
			n = cnt[0];
			wr(OFS_START, 32'h1);
			idle(4);
			chk(cnt[0] - n, o);
			idle(30);
			chk(gap[0], 7);
			wr(OFS_STOP, 32'h1);
			wr(8'h0c, 32'd10);
			wr(8'h08, 8 + o);
			n = cnt[1];
			wr(OFS_START, 32'h2);
			wr(OFS_START, 32'h2);
			idle(30);
			chk(cnt[1] - n, 1 + o);
			rd(OFS_RUNNING);
		end
		wr(OFS_DATA_BASE, 32'd9);
		wr(8'h0c, 32'd3);
		wr(8'h08, 32'h0408);
		wr(OFS_OUT_MODE, 32'h2);
		n = rises;
		wr(OFS_START, 32'h1);
		idle(55);
		chk(32'(rises - n > 3), 1);
		wr(OFS_STOP, 32'h3);
		for (int e = 0; e < 4; e++) begin
			wr(8'h14, 32'd2);
			wr(8'h10, (e << 6) | 6);
			wr(OFS_START, 32'h4);
			n = cnt[2];
			idle(8);
			chk(cnt[2] - n, 0);
			pins(2, 12, 3);
			chk(32'(cnt[2] > n), 1);
			wr(OFS_STOP, 32'h4);
		end
		wr(8'h18, 32'h0144);
		wr(OFS_START, 32'h8);
		n = cnt[3];
		pins(3, 4, 9);
		chk(cnt[3] - n, 2);
		xfer(1'b0, 8'h2c, 32'h0);
		chk(32'(r[31:16] >= 16'd18 && r[31:16] <= 16'd22), 1);
		// high-width measure: opens on rise, closes on fall, one irq
		wr(8'h10, 32'h00cc);
		n = cnt[2];
		pins(2, 2, 9);
		chk(cnt[2] - n, 1);
		xfer(1'b0, 8'h28, 32'h0);
		chk(32'(r[31:16] >= 16'd8 && r[31:16] <= 16'd10), 1);
		ce <= 1'b0;
		idle(3);
		ce <= 1'b1;
		idle(2);
		close_out();
	end
endmodule : timer_array_tb
`default_nettype wire
